// >>> src/sec_cfg_pkg.sv
// Constants and carrier types for the secondary-side bridge configuration registers.
// Assumes an APB master with 32-bit data on the PCI clock domain.
package sec_cfg_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] cmd_offset      = 8'h04;
    localparam logic [7:0] bus_lat_offset  = 8'h18;
    localparam logic [7:0] io_stat_offset  = 8'h1c;
    localparam logic [7:0] mem_win_offset  = 8'h20;
    localparam logic [7:0] io_upper_offset = 8'h30;

    // ==========================================================
    // Field positions and fixed values
    localparam int         perr_resp_bit   = 6;
    localparam logic [3:0] io_addr32_code  = 4'h1;
    localparam logic [1:0] devsel_medium   = 2'h1;
    localparam logic [11:0] io_low_zero    = 12'h000;
    localparam logic [11:0] io_low_ones    = 12'hfff;
    localparam logic [19:0] mem_low_zero   = 20'h00000;
    localparam logic [19:0] mem_low_ones   = 20'hfffff;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  bus_rst        = 8'h00;
    localparam logic [7:0]  lat_rst        = 8'h00;
    localparam logic [3:0]  io_nib_rst     = 4'h0;
    localparam logic [15:0] io_upper_rst   = 16'h0000;
    localparam logic [11:0] mem_field_rst  = 12'h000;
    localparam logic [4:0]  flags_rst      = 5'h00;

    // Secondary bus events reported by the bridge datapath, one-cycle pulses
    typedef struct packed {
        logic target_abort_sent;
        logic target_abort_got;
        logic master_abort_got;
        logic parity_detected;
    } sec_event_t;

    // Secondary master cycle state reported by the bridge master engine
    typedef struct packed {
        logic frame_start;
        logic master_active;
        logic grant;
        logic mem_write_inval;
        logic data_phase_done;
    } sec_master_t;

endpackage : sec_cfg_pkg

// >>> src/sec_cfg_regs.sv
// Secondary-side configuration registers of a two-port bridge, with APB slave,
// latency timer, status flags and I/O and memory forwarding window decode.
// Assumes event and master inputs come from logic on pclk; fault pins are async.
//
// Functional notes
// - Subordinate bus number, 8-bit writable, resets to zero.
// - Latency timer counts clocks from frame start; expiry from writable field.
// - Latency zero and grant removed: stop after first data phase, except MWI.
// - I/O base and limit indicator nibbles read 1 for 32-bit I/O.
// - I/O base nibble gives window bottom bits 15:12, low bits zero.
// - I/O limit nibble gives window top bits 15:12, low bits ones.
// - Upper halfword registers give window bits 31:16 for full compare.
// - 66 MHz capable status bit reads one.
// - Fast back-to-back capable status bit reads one.
// - Data parity flag set on parity fault pin while command bit 6 set.
// - Select-timing field reads binary 01.
// - Signaled target abort flag set when bridge target aborts.
// - Received target abort flag set on mastered cycle target abort.
// - Received master abort flag set on mastered cycle master abort.
// - Received system error flag set when system fault pin asserted.
// - Detected parity error flag set on secondary parity error.
// - Memory base field gives window bottom bits 31:20, low bits zero.
// - Memory limit field gives window top bits 31:20, low bits ones.
module sec_cfg_regs
    import sec_cfg_pkg::*;
#(
    parameter int lat_w = 8
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Secondary fault pins, active low, asynchronous
    input  wire logic                  secondary_parity_fault_line_n,
    input  wire logic                  secondary_system_fault_line_n,
    // Bridge datapath
    input  wire sec_cfg_pkg::sec_event_t  sec_event,
    input  wire sec_cfg_pkg::sec_master_t sec_master,
    input  wire logic [31:0]           io_addr,
    input  wire logic [31:0]           mem_addr,
    output logic                       latency_expired,
    output logic                       end_after_first,
    output logic                       io_hit,
    output logic                       mem_hit
);
    import sec_cfg_pkg::*;

    // ==========================================================
    // Register state
    logic [7:0]       subordinate_bus_number;
    logic [lat_w-1:0] secondary_latency_timer;
    logic [3:0]       io_base_nib;
    logic [3:0]       io_limit_nib;
    logic [15:0]      io_base_upper;
    logic [15:0]      io_limit_upper;
    logic [11:0]      memory_window_base;
    logic [11:0]      memory_window_limit;
    logic             perr_response;
    logic [4:0]       flags;          // Bits 31:27 packed: {31,30,29,28,27}; bit 24 is parity_reported
    logic             parity_reported;
    logic [lat_w-1:0] lat_count;

    // ==========================================================
    // Pin synchronisers; first stage read only by second stage
    logic perr_meta, perr_sync_n;
    logic serr_meta, serr_sync_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            perr_meta   <= 1'b1;
            perr_sync_n <= 1'b1;
            serr_meta   <= 1'b1;
            serr_sync_n <= 1'b1;
        end else begin
            perr_meta   <= secondary_parity_fault_line_n;
            perr_sync_n <= perr_meta;
            serr_meta   <= secondary_system_fault_line_n;
            serr_sync_n <= serr_meta;
        end
    end

    // ==========================================================
    // APB decode; one wait state so read data comes from a flop
    logic        acc;
    logic        wr_fire;
    logic        mapped;
    logic [31:0] wmask;
    logic [31:0] status_word;
    logic [31:0] next_rdata;

    assign acc     = psel && penable;
    assign wr_fire = acc && pready && pwrite;
    assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign mapped  = (paddr == cmd_offset) || (paddr == bus_lat_offset) ||
                     (paddr == io_stat_offset) || (paddr == mem_win_offset) ||
                     (paddr == io_upper_offset);

    // Status halfword with fixed capability bits, above the I/O base and limit bytes
    assign status_word = {flags, devsel_medium, parity_reported,
                          1'b1, 1'b0, 1'b1, 5'h00,
                          io_limit_nib, io_addr32_code,
                          io_base_nib, io_addr32_code};

    // Read mux; unmapped reads return zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            cmd_offset:      next_rdata[perr_resp_bit] = perr_response;
            bus_lat_offset:  next_rdata = {secondary_latency_timer, subordinate_bus_number, 16'h0000};
            io_stat_offset:  next_rdata = {status_word[31:27], status_word[26:25], status_word[24:0]};
            mem_win_offset:  next_rdata = {memory_window_limit, 4'h0, memory_window_base, 4'h0};
            io_upper_offset: next_rdata = {io_limit_upper, io_base_upper};
            default:         next_rdata = 32'h0000_0000;
        endcase
    end

    // Answer handshake: pready pulses one cycle after the access phase starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc && !pready;
            pslverr <= acc && !pready && !mapped;
            if (acc && !pready && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // ==========================================================
    // Writable fields, honouring byte strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            subordinate_bus_number  <= bus_rst;
            secondary_latency_timer <= lat_rst;
            perr_response           <= 1'b0;
        end else if (wr_fire && paddr == cmd_offset && pstrb[0]) begin
            perr_response <= pwdata[perr_resp_bit];
        end else if (wr_fire && paddr == bus_lat_offset) begin
            if (pstrb[2]) begin
                subordinate_bus_number <= pwdata[23:16];
            end
            if (pstrb[3]) begin
                secondary_latency_timer <= pwdata[24 +: lat_w];
            end
        end
    end

    // I/O and memory window fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_base_nib         <= io_nib_rst;
            io_limit_nib        <= io_nib_rst;
            io_base_upper       <= io_upper_rst;
            io_limit_upper      <= io_upper_rst;
            memory_window_base  <= mem_field_rst;
            memory_window_limit <= mem_field_rst;
        end else if (wr_fire) begin
            if (paddr == io_stat_offset && pstrb[0]) begin
                io_base_nib <= pwdata[7:4];
            end
            if (paddr == io_stat_offset && pstrb[1]) begin
                io_limit_nib <= pwdata[15:12];
            end
            if (paddr == io_upper_offset) begin
                io_base_upper  <= (pwdata[15:0] & wmask[15:0]) |
                                  (io_base_upper & ~wmask[15:0]);
                io_limit_upper <= (pwdata[31:16] & wmask[31:16]) |
                                  (io_limit_upper & ~wmask[31:16]);
            end
            if (paddr == mem_win_offset) begin
                memory_window_base  <= (pwdata[15:4] & wmask[15:4]) |
                                       (memory_window_base & ~wmask[15:4]);
                memory_window_limit <= (pwdata[31:20] & wmask[31:20]) |
                                       (memory_window_limit & ~wmask[31:20]);
            end
        end
    end

    // ==========================================================
    // Sticky status flags; a set in the same cycle as a clear wins
    logic [4:0] flag_set;
    logic [4:0] flag_clr;
    logic       perr_set;
    logic       perr_clr;

    assign flag_set = {sec_event.parity_detected,
                       !serr_sync_n,
                       sec_event.master_abort_got,
                       sec_event.target_abort_got,
                       sec_event.target_abort_sent};
    assign flag_clr = (wr_fire && paddr == io_stat_offset && pstrb[3]) ?
                      pwdata[31:27] : 5'h00;
    assign perr_set = !perr_sync_n && perr_response;
    assign perr_clr = wr_fire && paddr == io_stat_offset && pstrb[3] && pwdata[24];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags           <= flags_rst;
            parity_reported <= 1'b0;
        end else begin
            flags           <= (flags & ~flag_clr) | flag_set;
            parity_reported <= (parity_reported && !perr_clr) || perr_set;
        end
    end

    // ==========================================================
    // Secondary master latency timer; saturates so expiry stays asserted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_count <= '0;
        end else if (sec_master.frame_start) begin
            lat_count <= '0;
        end else if (sec_master.master_active && lat_count != '1) begin
            lat_count <= lat_count + 1'b1;
        end
    end

    // Expiry and first-phase stop; MWI is exempt because it runs to a line end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latency_expired <= 1'b0;
            end_after_first <= 1'b0;
        end else begin
            latency_expired <= sec_master.master_active &&
                               !sec_master.frame_start &&
                               lat_count >= secondary_latency_timer;
            end_after_first <= sec_master.master_active &&
                               secondary_latency_timer == '0 &&
                               !sec_master.grant &&
                               !sec_master.mem_write_inval &&
                               sec_master.data_phase_done;
        end
    end

    // ==========================================================
    // Forwarding window decode with full 32-bit bounds, inclusive
    logic [31:0] io_lo, io_hi, mem_lo, mem_hi;

    assign io_lo  = {io_base_upper, io_base_nib, io_low_zero};
    assign io_hi  = {io_limit_upper, io_limit_nib, io_low_ones};
    assign mem_lo = {memory_window_base, mem_low_zero};
    assign mem_hi = {memory_window_limit, mem_low_ones};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_hit  <= 1'b0;
            mem_hit <= 1'b0;
        end else begin
            io_hit  <= io_addr >= io_lo && io_addr <= io_hi;
            mem_hit <= mem_addr >= mem_lo && mem_addr <= mem_hi;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_write(logic [7:0] a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence

    sequence s_read_answer(logic [7:0] a);
        psel && penable && pready && !pwrite && paddr == a;
    endsequence

    a_sub_bus_write: assert property (s_write(bus_lat_offset) ##0 pstrb[2] |=>
        subordinate_bus_number == $past(pwdata[23:16]))
        else $error("subordinate bus number not written");

    a_lat_expiry: assert property (sec_master.master_active && !sec_master.frame_start &&
        lat_count >= secondary_latency_timer |=> latency_expired)
        else $error("latency timer did not expire");

    a_first_phase_stop: assert property (sec_master.master_active &&
        secondary_latency_timer == '0 && !sec_master.grant &&
        !sec_master.mem_write_inval && sec_master.data_phase_done |=> end_after_first)
        else $error("no stop after first data phase");

    a_io_indicator: assert property (s_read_answer(io_stat_offset) |->
        prdata[3:0] == 4'h1 && prdata[11:8] == 4'h1)
        else $error("I/O addressing indicator wrong");

    a_status_fixed: assert property (s_read_answer(io_stat_offset) |->
        prdata[21] && prdata[23] && prdata[26:25] == devsel_medium && prdata[20:16] == 5'h00)
        else $error("fixed status bits wrong");

    a_parity_report: assert property (!perr_sync_n && perr_response |=>
        parity_reported)
        else $error("data parity flag not set");

    a_serr_flag: assert property ((!secondary_system_fault_line_n)[*3] |=> flags[3])
        else $error("system error flag not set");

    a_flag_w1c: assert property (s_write(io_stat_offset) ##0 (pstrb[3] && pwdata[29] &&
        !sec_event.master_abort_got) |=> !flags[2])
        else $error("master abort flag not cleared");

    a_master_abort: assert property (sec_event.master_abort_got ##1 !flag_clr[2] |->
        flags[2] [*2])
        else $error("master abort flag not held");

    a_io_window: assert property (io_addr == {io_base_upper, io_base_nib, 12'h000} &&
        io_lo <= io_hi |=> io_hit)
        else $error("I/O window bottom not inclusive");

    a_mem_window: assert property (mem_addr == {memory_window_limit, 20'hfffff} &&
        mem_lo <= mem_hi |=> mem_hit)
        else $error("memory window top not inclusive");

    a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB answer timing wrong");

    a_target_abort_sent: assert property (sec_event.target_abort_sent |=> flags[0])
        else $error("signaled target abort flag not set");

    a_target_abort_got: assert property (sec_event.target_abort_got |=> flags[1])
        else $error("received target abort flag not set");

    a_parity_detect: assert property (sec_event.parity_detected |=> flags[4])
        else $error("detected parity flag not set");

    a_io_top: assert property (io_addr == io_hi && io_lo <= io_hi |=>
        io_hit)
        else $error("I/O window top not inclusive");

    a_mem_bottom: assert property (mem_addr == mem_lo && mem_lo <= mem_hi |=>
        mem_hit)
        else $error("memory window bottom not inclusive");

    a_unmapped_error: assert property (psel && penable && pready && !mapped |-> pslverr)
        else $error("unmapped access without error response");

endmodule : sec_cfg_regs

// >>> testbench/sec_agent.sv
// Model of the bus agents and master engine on the bridge's secondary side.
// Assumes the bench calls its tasks between clock edges; everything moves on pclk.
module sec_agent
    import sec_cfg_pkg::*;
(
    // Clock
    input  wire logic          pclk,
    // Secondary side signals seen by the register block
    output logic               secondary_parity_fault_line_n,
    output logic               secondary_system_fault_line_n,
    output sec_cfg_pkg::sec_event_t  sec_event,
    output sec_cfg_pkg::sec_master_t sec_master
);
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Idle levels: pins released high, no events, no mastering
    initial begin
        secondary_parity_fault_line_n = 1'b1;
        secondary_system_fault_line_n = 1'b1;
        sec_event                     = '0;
        sec_master                    = '0;
    end

    // One-cycle event pulse, as the datapath reports it
    task automatic event_pulse(input sec_event_t ev);
        @(posedge pclk);
        sec_event <= ev;
        @(posedge pclk);
        sec_event <= '0;
    endtask : event_pulse

    // Fault pin held low long enough to pass the two-flop synchroniser
    task automatic fault_pin(input logic sys, input int hold);
        @(posedge pclk);
        if (sys) secondary_system_fault_line_n <= 1'b0;
        else secondary_parity_fault_line_n <= 1'b0;
        repeat (hold) @(posedge pclk);
        secondary_system_fault_line_n <= 1'b1;
        secondary_parity_fault_line_n <= 1'b1;
    endtask : fault_pin

    // Frame start pulse, then master_active held until master_end
    task automatic master_start(input logic gnt, input logic mwi);
        @(posedge pclk);
        sec_master <= '{frame_start: 1'b1, master_active: 1'b1, grant: gnt,
                        mem_write_inval: mwi, data_phase_done: 1'b0};
        @(posedge pclk);
        sec_master.frame_start <= 1'b0;
    endtask : master_start

    // One completed data phase
    task automatic data_done();
        @(posedge pclk);
        sec_master.data_phase_done <= 1'b1;
        @(posedge pclk);
        sec_master.data_phase_done <= 1'b0;
    endtask : data_done

    // Bus released
    task automatic master_end();
        @(posedge pclk);
        sec_master <= '0;
    endtask : master_end
endmodule : sec_agent

// >>> testbench/sec_cfg_regs_tb.sv
// Self-checking bench for the secondary-side configuration registers.
// Assumes one 10 MHz clock; APB accesses and agent stimulus never overlap.
module sec_cfg_regs_tb;
    import sec_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, io_addr, mem_addr;
    logic [3:0]  pstrb;
    logic        par_n, sys_n, latency_expired, end_after_first, io_hit, mem_hit;
    sec_event_t  sec_event;
    sec_master_t sec_master;
    int          failures, cmp_count, n;
    logic [31:0] st;
    logic [33:0] hits [9];
    int          flag_bit [4];
    logic [2:0]  eaf [3];

    // ==========================================================
    // Clock, design and far-side model
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    sec_cfg_regs #(.lat_w(8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .secondary_parity_fault_line_n(par_n),
        .secondary_system_fault_line_n(sys_n), .sec_event(sec_event),
        .sec_master(sec_master), .io_addr(io_addr), .mem_addr(mem_addr),
        .latency_expired(latency_expired), .end_after_first(end_after_first),
        .io_hit(io_hit), .mem_hit(mem_hit));

    sec_agent agent (
        .pclk(pclk), .secondary_parity_fault_line_n(par_n),
        .secondary_system_fault_line_n(sys_n), .sec_event(sec_event),
        .sec_master(sec_master));

    // ==========================================================
    // Compare tasks and verdict
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: data got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask : chk1

    task automatic tally_and_finish();
        if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // APB master: request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, s, r, e);
        chk1(e, a == 8'h10);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, 4'hf, r, e);
        chk32(r, exp);
        chk1(e, ee);
    endtask : rd_chk

    // Window decode: hit flags registered one cycle after the address
    task automatic hit_chk(input logic [33:0] h);
        @(posedge pclk);
        io_addr <= h[33:2];
        mem_addr <= h[33:2];
        @(posedge pclk);
        @(negedge pclk);
        chk1(io_hit, h[1]);
        chk1(mem_hit, h[0]);
    endtask : hit_chk

    // ==========================================================
    // Test sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        io_addr = 32'h0;
        mem_addr = 32'h0;
        failures = 0;
        cmp_count = 0;
        presetn = 1'b0;
        hits = '{{32'h0001_2000, 2'b10}, {32'h0001_1fff, 2'b00}, {32'h0001_3fff, 2'b10},
                 {32'h0001_4000, 2'b00}, {32'h0000_2000, 2'b00}, {32'h1230_0000, 2'b01},
                 {32'h122f_ffff, 2'b00}, {32'h124f_ffff, 2'b01}, {32'h1250_0000, 2'b00}};
        flag_bit = '{31, 29, 28, 27};
        eaf = '{3'b001, 3'b100, 3'b010};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and fixed read-only fields
        rd_chk(bus_lat_offset, 32'h0, 1'b0);
        rd_chk(io_stat_offset, 32'h02a0_0101, 1'b0);
        rd_chk(mem_win_offset, 32'h0, 1'b0);
        rd_chk(8'h10, 32'h0, 1'b1);
        wr(8'h10, 32'hffff_ffff, 4'hf);
        // Writable fields, byte strobes and read-only bits
        wr(bus_lat_offset, 32'hffff_ffff, 4'hf);
        rd_chk(bus_lat_offset, 32'hffff_0000, 1'b0);
        wr(bus_lat_offset, 32'h1234_5678, 4'h4);
        rd_chk(bus_lat_offset, 32'hff34_0000, 1'b0);
        wr(io_stat_offset, 32'h00ff_3020, 4'hf);
        wr(io_upper_offset, 32'h0001_0001, 4'hf);
        st = 32'h02a0_3121;
        rd_chk(io_stat_offset, st, 1'b0);
        wr(mem_win_offset, 32'h1245_1236, 4'hf);
        rd_chk(mem_win_offset, 32'h1240_1230, 1'b0);
        // Forwarding windows at and beyond their bounds
        foreach (hits[i]) hit_chk(hits[i]);
        // Sticky event flags: zero write keeps them, one write clears them
        for (int i = 0; i < 4; i++) begin
            agent.event_pulse(sec_event_t'(4'b0001 << i));
            wr(io_stat_offset, 32'h0, 4'h8);
            rd_chk(io_stat_offset, st | (32'h1 << flag_bit[i]), 1'b0);
            wr(io_stat_offset, 32'h1 << flag_bit[i], 4'h8);
            rd_chk(io_stat_offset, st, 1'b0);
        end
        // Fault pins; parity is reported only with the response bit set
        agent.fault_pin(1'b1, 4);
        rd_chk(io_stat_offset, st | 32'h4000_0000, 1'b0);
        wr(io_stat_offset, 32'h4000_0000, 4'h8);
        agent.fault_pin(1'b0, 4);
        rd_chk(io_stat_offset, st, 1'b0);
        wr(cmd_offset, 32'h1 << perr_resp_bit, 4'hf);
        agent.fault_pin(1'b0, 4);
        rd_chk(io_stat_offset, st | 32'h0100_0000, 1'b0);
        wr(io_stat_offset, 32'h0100_0000, 4'h8);
        rd_chk(io_stat_offset, st, 1'b0);
        // Latency timer with a setting of 2
        wr(bus_lat_offset, 32'h0200_0000, 4'h8);
        agent.master_start(1'b1, 1'b0);
        @(negedge pclk);
        chk1(latency_expired, 1'b0);
        n = 0;
        while (latency_expired !== 1'b1 && n < 10) begin
            @(negedge pclk);
            n++;
        end
        chk1(latency_expired, 1'b1);
        chk1(n == 3, 1'b1);
        agent.master_end();
        repeat (2) @(negedge pclk);
        chk1(latency_expired, 1'b0);
        // Early stop with setting 0: grant kept or write-and-invalidate both prevent it
        wr(bus_lat_offset, 32'h0, 4'h8);
        foreach (eaf[i]) begin
            agent.master_start(eaf[i][2], eaf[i][1]);
            agent.data_done();
            @(negedge pclk);
            chk1(end_after_first, eaf[i][0]);
            agent.master_end();
        end
        tally_and_finish();
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        #200_000;
        failures++;
        tally_and_finish();
    end
endmodule : sec_cfg_regs_tb
